// *** lsw_defines.vh ***
// Constants for the lamp switch serial control port: frame layout,
// register addresses, field positions, reset values and timing counts.
// Assumes a single 50 MHz system clock; included by lsw_serial_port.v.
`ifndef LSW_DEFINES_VH
`define LSW_DEFINES_VH

// Frame layout: address in the top five bits, data below
`define LSW_FRAME_BITS   16
`define LSW_ADDR_HI      15
`define LSW_ADDR_LO      11
`define LSW_DATA_HI      10

// Register addresses
`define LSW_ADDR_CTRL    5'h00
`define LSW_ADDR_DUTY0   5'h01
`define LSW_ADDR_DUTY1   5'h02
`define LSW_ADDR_FCLR    5'h03

// Control register fields
`define LSW_CTRL_ON0     0
`define LSW_CTRL_ON1     1
`define LSW_CTRL_PWM_EN  2
`define LSW_CTRL_CLK_SEL 3
`define LSW_CTRL_DIS0    4
`define LSW_CTRL_DIS1    5
`define LSW_CTRL_RESET   6'h00
`define LSW_DUTY_RESET   7'h00

// Timing: figures in their own units, cycle counts derived from the clock
`define LSW_CLK_MHZ      50
`define LSW_WDT_MS       310
`define LSW_CLKFAIL_US   1000
`define LSW_INT_PWM_HZ   15360
`define LSW_PWM_DIV      128
`define LSW_WDT_CYC      (`LSW_WDT_MS * 1000 * `LSW_CLK_MHZ)
`define LSW_CLKFAIL_CYC  (`LSW_CLKFAIL_US * `LSW_CLK_MHZ)
`define LSW_INT_DIV_CYC  ((`LSW_CLK_MHZ * 1000000) / `LSW_INT_PWM_HZ)

`endif

// *** lsw_serial_port.v ***
// Serial control port and pin-level control of a dual high-side lamp switch.
// Assumes all pins are already synchronous to mclk_in and that the serial
// clock stays well below a quarter of mclk_in so every edge is seen.
//
// Operation
// - Serial input is sampled on each serial clock falling edge while selected.
// - Frames are sixteen bits, most significant bit first, both directions.
// - A five-bit address field in each frame picks the target register.
// - Select rising copies the received frame into the addressed register.
// - Select falling loads output status into the transmit shift register.
// - Serial output is driven only while select is low, else released.
// - Serial clock and input are ignored while select is high.
// - Serial output changes on each rising serial clock edge after the first.
// - Reset pin low clears configuration and faults and forces sleep.
// - Watchdog starts when the reset pin rises.
// - Only reset pin high clears sleep; direct input, wake or PWM clock activity also let the outputs switch.
// - Direct inputs switch their outputs with PWM off and disable bit clear, or in fail-safe; input 0 carries external PWM clock.
// - PWM period is the PWM clock divided by 128.
// - Clock-failure detection only runs with PWM enabled and external clock.
// - Open-drain fault flag pulls low on any fault; causes go in status.
// - Loss of serial interface supply enters fail-safe mode.
// - Watchdog times out 310 ms after reset rising with fail-safe input open.
`include "lsw_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module lsw_serial_port #(
    parameter integer WDT_CYC     = `LSW_WDT_CYC,
    parameter integer CLKFAIL_CYC = `LSW_CLKFAIL_CYC,
    parameter integer INT_DIV_CYC = `LSW_INT_DIV_CYC
) (
    input  wire        mclk_in,
    input  wire        rst_in,
    input  wire        select_n_in,
    input  wire        sclk_in,
    input  wire        si_in,
    output wire        so_out,
    output wire        so_oe_out,
    input  wire        reset_n_in,
    input  wire        wake_in,
    input  wire        direct_input_0_in,
    input  wire        direct_input_1_in,
    input  wire        failsafe_config_in,
    input  wire        vdd_fail_in,
    input  wire [1:0]  fault_in,
    output reg         switch_output_0_out,
    output reg         switch_output_1_out,
    output wire        fault_flag_n_out,
    output wire        fault_flag_n_oe_out,
    output reg         sleep_out,
    output reg         failsafe_out
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    reg        sel_n_r;
    reg        sclk_r;
    reg        in0_r;
    reg        rstpin_r;
    reg [15:0] rx_r;
    reg [15:0] tx_r;
    reg [4:0]  bits_r;
    reg [5:0]  ctrl_r;
    reg [6:0]  duty0_r;
    reg [6:0]  duty1_r;
    reg [1:0]  fault_r;
    reg        clk_fail_r;
    reg [31:0] wdt_cnt_r;
    reg        wdt_run_r;
    reg        wdt_to_r;
    reg [31:0] act_cnt_r;
    reg        clock_on_r;
    reg [31:0] div_cnt_r;
    reg [6:0]  pwm_cnt_r;
    reg        hson0_nxt;
    reg        hson1_nxt;

    wire sel_fall  = sel_n_r & ~select_n_in;
    wire sel_rise  = ~sel_n_r & select_n_in;
    wire sclk_rise = ~select_n_in & ~sel_n_r & ~sclk_r & sclk_in;
    wire sclk_fall = ~select_n_in & ~sel_n_r & sclk_r & ~sclk_in;
    wire in0_edge  = in0_r & ~direct_input_0_in;
    wire ext_edge  = ~in0_r & direct_input_0_in;
    wire pwm_en    = ctrl_r[`LSW_CTRL_PWM_EN];
    wire ext_sel   = pwm_en & ~ctrl_r[`LSW_CTRL_CLK_SEL];
    wire frame_ok  = sel_rise & (bits_r == 5'd16);
    wire [4:0] frame_addr = rx_r[`LSW_ADDR_HI:`LSW_ADDR_LO];
    wire wake      = reset_n_in | wake_in | direct_input_0_in | direct_input_1_in
                     | clock_on_r;
    wire fail      = vdd_fail_in | (wdt_to_r & failsafe_config_in);
    wire int_tick  = (div_cnt_r == INT_DIV_CYC - 1);
    wire pwm_tick  = ctrl_r[`LSW_CTRL_CLK_SEL] ? int_tick : ext_edge;
    wire any_fault = |fault_r | clk_fail_r;

    // Pulse-width compare: duty n gives n+1 of 128 slots on, 127 fully on
    function pwm_on;
        input [6:0] cnt;
        input [6:0] duty;
        begin
            pwm_on = (cnt <= duty);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin history for edge detection
    // One stage is enough as the pins are already synchronous to mclk_in
    always @(posedge mclk_in) begin
        if (rst_in) begin
            sel_n_r  <= 1'b1;
            sclk_r   <= 1'b0;
            in0_r    <= 1'b0;
            rstpin_r <= 1'b0;
        end else begin
            sel_n_r  <= select_n_in;
            sclk_r   <= sclk_in;
            in0_r    <= direct_input_0_in;
            rstpin_r <= reset_n_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive side: sample on falling clock, count bits, saturate at 31
    // Saturation keeps a long frame from wrapping back round to sixteen
    always @(posedge mclk_in) begin
        if (rst_in) begin
            rx_r   <= 16'h0000;
            bits_r <= 5'h00;
        end else if (sel_fall) begin
            bits_r <= 5'h00;
        end else if (sclk_fall) begin
            rx_r <= {rx_r[14:0], si_in};
            if (bits_r != 5'h1f) begin
                bits_r <= bits_r + 5'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit side: status loaded at select falling, shifted on rising clock.
    // The top bit shows from select falling and is held through the first
    // rising edge, as no falling edge has been counted yet. Each later rising
    // edge moves one bit on, so the master takes bit 15 at its first falling
    // edge and bit 0 at its sixteenth.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            tx_r <= 16'h0000;
        end else if (sel_fall) begin
            tx_r <= {fault_r, clk_fail_r, failsafe_out, sleep_out, wdt_to_r,
                     direct_input_1_in, direct_input_0_in,
                     switch_output_1_out, switch_output_0_out, 6'h00};
        end else if (sclk_rise && bits_r != 5'h00) begin
            tx_r <= {tx_r[14:0], 1'b0};
        end
    end

    // Driver released whenever select is high
    assign so_out    = tx_r[15];
    assign so_oe_out = ~sel_n_r & ~select_n_in;

    ////////////////////////////////////////////////////////////////////////
    // Register write at select rising; short or long frames are dropped.
    // A partly shifted word would carry a stale address, so it never lands.
    // Set wins over the clear so a fault landing with the clear is kept.
    always @(posedge mclk_in) begin
        if (rst_in | ~reset_n_in) begin
            ctrl_r  <= `LSW_CTRL_RESET;
            duty0_r <= `LSW_DUTY_RESET;
            duty1_r <= `LSW_DUTY_RESET;
            fault_r <= 2'b00;
        end else begin
            if (frame_ok) begin
                if (frame_addr == `LSW_ADDR_CTRL) begin
                    ctrl_r <= rx_r[5:0];
                end else if (frame_addr == `LSW_ADDR_DUTY0) begin
                    duty0_r <= rx_r[6:0];
                end else if (frame_addr == `LSW_ADDR_DUTY1) begin
                    duty1_r <= rx_r[6:0];
                end
            end
            if (frame_ok && frame_addr == `LSW_ADDR_FCLR) begin
                fault_r <= (fault_r & ~rx_r[1:0]) | fault_in;
            end else begin
                fault_r <= fault_r | fault_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog: armed by reset pin rising, refreshed by every good frame
    // The timeout flag is sticky until the reset pin goes low, so a master
    // that stops framing leaves the outputs to the direct inputs for good when the fail-safe input is set.
    always @(posedge mclk_in) begin
        if (rst_in | ~reset_n_in) begin
            wdt_cnt_r <= 32'h0000_0000;
            wdt_run_r <= 1'b0;
            wdt_to_r  <= 1'b0;
        end else if (~rstpin_r | frame_ok) begin
            wdt_cnt_r <= 32'h0000_0000;
            wdt_run_r <= 1'b1;
        end else if (wdt_run_r) begin
            if (wdt_cnt_r == WDT_CYC - 1) begin
                wdt_to_r  <= 1'b1;
                wdt_run_r <= 1'b0;
            end else begin
                wdt_cnt_r <= wdt_cnt_r + 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PWM clock activity and clock-failure detection on direct input 0.
    // Activity holds for one low-frequency period after each edge.
    // Either edge counts, so a clock stuck at either level still wakes once.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            act_cnt_r  <= 32'h0000_0000;
            clock_on_r <= 1'b0;
            clk_fail_r <= 1'b0;
        end else begin
            if (in0_edge | ext_edge) begin
                act_cnt_r  <= 32'h0000_0000;
                clock_on_r <= 1'b1;
            end else if (act_cnt_r == CLKFAIL_CYC - 1) begin
                clock_on_r <= 1'b0;
            end else begin
                act_cnt_r <= act_cnt_r + 32'h0000_0001;
            end
            if (~reset_n_in | ~ext_sel) begin
                clk_fail_r <= 1'b0;
            end else if (act_cnt_r == CLKFAIL_CYC - 1) begin
                clk_fail_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PWM counter: one step per PWM clock, wraps every 128 steps
    // The internal divider runs free so its rate is fixed whichever
    // clock source a frame selects.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            div_cnt_r <= 32'h0000_0000;
            pwm_cnt_r <= 7'h00;
        end else begin
            div_cnt_r <= int_tick ? 32'h0000_0000 : div_cnt_r + 32'h0000_0001;
            if (pwm_tick) begin
                pwm_cnt_r <= pwm_cnt_r + 7'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output decision: fail-safe follows inputs, otherwise direct or PWM
    // Fail-safe is tested first so a dead master cannot keep lamps dark
    always @* begin
        if (fail) begin
            hson0_nxt = direct_input_0_in;
            hson1_nxt = direct_input_1_in;
        end else if (pwm_en) begin
            hson0_nxt = ctrl_r[`LSW_CTRL_ON0] & pwm_on(pwm_cnt_r, duty0_r);
            hson1_nxt = ctrl_r[`LSW_CTRL_ON1] & pwm_on(pwm_cnt_r, duty1_r);
        end else begin
            hson0_nxt = (direct_input_0_in & ~ctrl_r[`LSW_CTRL_DIS0])
                        | ctrl_r[`LSW_CTRL_ON0];
            hson1_nxt = (direct_input_1_in & ~ctrl_r[`LSW_CTRL_DIS1])
                        | ctrl_r[`LSW_CTRL_ON1];
        end
    end

    // Faulted outputs are forced off; loss of every wake source turns everything off
    always @(posedge mclk_in) begin
        if (rst_in) begin
            switch_output_0_out <= 1'b0;
            switch_output_1_out <= 1'b0;
            sleep_out           <= 1'b1;
            failsafe_out        <= 1'b0;
        end else begin
            sleep_out           <= ~wake | ~reset_n_in;
            failsafe_out        <= wake & fail;
            switch_output_0_out <= wake & hson0_nxt & ~fault_r[0];
            switch_output_1_out <= wake & hson1_nxt & ~fault_r[1];
        end
    end

    // Open-drain flag: only ever pulls low
    // The pad needs an outside pull-up; it reads high while released
    assign fault_flag_n_out    = 1'b0;
    assign fault_flag_n_oe_out = any_fault;

endmodule

`default_nettype wire

// *** lsw_serial_port_sva.sv ***
// Checker for the lamp switch serial port: output enable, shifting, flags.
// Assumes it is bound to lsw_serial_port and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module lsw_serial_port_sva (
    input wire logic       mclk_in,
    input wire logic       rst_in,
    input wire logic       select_n_in,
    input wire logic       sclk_in,
    input wire logic       so_out,
    input wire logic       so_oe_out,
    input wire logic       reset_n_in,
    input wire logic       vdd_fail_in,
    input wire logic [1:0] fault_in,
    input wire logic       switch_output_0_out,
    input wire logic       switch_output_1_out,
    input wire logic       fault_flag_n_out,
    input wire logic       fault_flag_n_oe_out,
    input wire logic       sleep_out,
    input wire logic       failsafe_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////////
    // Select seen low on two edges after a fall
    sequence s_open;
        $fell(select_n_in) ##1 !select_n_in;
    endsequence
    property p_oe_only_sel;
        so_oe_out |-> !select_n_in && !$past(select_n_in);
    endproperty
    property p_oe_on;
        s_open |-> so_oe_out;
    endproperty
    // Load edge is excluded: only a seen clock rise may move the bit
    property p_so_shift;
        so_oe_out && $past(so_oe_out) && $changed(so_out) |-> $past(sclk_in) && !$past(sclk_in, 2);
    endproperty
    property p_sleep;
        !reset_n_in |=> sleep_out && !switch_output_0_out && !switch_output_1_out;
    endproperty
    property p_wake;
        reset_n_in [*3] |=> !sleep_out;
    endproperty
    property p_flag_low;
        fault_flag_n_oe_out |-> !fault_flag_n_out;
    endproperty
    property p_flag_on;
        reset_n_in && fault_in != 2'h0 |-> ##[1:3] fault_flag_n_oe_out;
    endproperty
    property p_fault_off;
        reset_n_in && fault_in[0] |-> ##[1:3] !switch_output_0_out;
    endproperty
    property p_vdd;
        reset_n_in && vdd_fail_in |-> ##[1:3] failsafe_out;
    endproperty
    a_oe_only_sel: assert property (p_oe_only_sel)
        else $error("serial output driven while deselected");
    a_oe_on: assert property (p_oe_on)
        else $error("serial output not driven after select");
    a_so_shift: assert property (p_so_shift)
        else $error("serial output moved without clock rise");
    a_sleep: assert property (p_sleep)
        else $error("reset pin low without sleep");
    a_wake: assert property (p_wake)
        else $error("reset pin high but still asleep");
    a_flag_low: assert property (p_flag_low)
        else $error("fault flag enabled but not low");
    a_flag_on: assert property (p_flag_on)
        else $error("fault flag not pulled low");
    a_fault_off: assert property (p_fault_off)
        else $error("faulted output still on");
    a_vdd: assert property (p_vdd)
        else $error("supply loss without fail-safe");
endmodule
bind lsw_serial_port lsw_serial_port_sva u_sva (.mclk_in(mclk_in), .rst_in(rst_in),
    .select_n_in(select_n_in), .sclk_in(sclk_in), .so_out(so_out), .so_oe_out(so_oe_out),
    .reset_n_in(reset_n_in), .vdd_fail_in(vdd_fail_in), .fault_in(fault_in),
    .switch_output_0_out(switch_output_0_out), .switch_output_1_out(switch_output_1_out),
    .fault_flag_n_out(fault_flag_n_out), .fault_flag_n_oe_out(fault_flag_n_oe_out),
    .sleep_out(sleep_out), .failsafe_out(failsafe_out));
`default_nettype wire

// *** lsw_spi_master.sv ***
// Serial master model for the lamp switch serial port.
// Assumes a 50 MHz clock; the bench starts frames through xfer.
`timescale 1ns/1ns
`default_nettype none
module lsw_spi_master (
    input  wire logic mclk_in,
    input  wire logic so_in,
    input  wire logic so_oe_in,
    output var  logic select_n_out = 1'b1,
    output var  logic sclk_out = 1'b0,
    output var  logic si_out = 1'b0
);
    ////////////////////////////////////////////////////////////////////////////
    // One frame; clock idles low so select never moves under a high clock
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        int i;
        rx = 16'h0000;
        @(posedge mclk_in);
        select_n_out <= 1'b0;
        repeat (25) @(posedge mclk_in);
        for (i = 0; i < nbits; i++) begin
            sclk_out <= 1'b1;
            si_out   <= tx[15 - i];
            repeat (4) @(posedge mclk_in);
            rx = {rx[14:0], so_oe_in ? so_in : 1'bx};
            sclk_out <= 1'b0;
            repeat (4) @(posedge mclk_in);
        end
        repeat (3) @(posedge mclk_in);
        select_n_out <= 1'b1;
        si_out       <= ~si_out; // Released line must not show a stale bit
        repeat (50) @(posedge mclk_in);
    endtask
endmodule
`default_nettype wire

// *** tb_lamp_switch_serial_control_port.sv ***
// Self-checking bench for the lamp switch serial port.
// Assumes the design, its defines header, master model and checker compile first.
`timescale 1ns/1ns
`default_nettype none
`include "lsw_defines.vh"
module tb_lamp_switch_serial_control_port;
    logic        mclk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        reset_n_in = 1'b0;
    logic [1:0]  din = 2'h0;
    logic        fs_cfg = 1'b0;
    logic        vdd_fail = 1'b0;
    logic [1:0]  fault = 2'h0;
    logic [15:0] rx;
    int          fail_count = 0;
    int          total_checks = 0;
    int          cycles = 0;
    wire         select_n, sclk, si, so, so_oe, sw0, sw1, flag_n, flag_oe, sleep, fsafe;
    // Open-drain flag against its pull-up
    wire         flag_level = flag_oe ? flag_n : 1'b1;
    // Rows: control bits, direct inputs, expected switch outputs
    localparam logic [9:0] ROWS [6] = '{{6'h00, 2'h0, 2'h0}, {6'h01, 2'h0, 2'h1},
        {6'h02, 2'h0, 2'h2}, {6'h00, 2'h3, 2'h3}, {6'h30, 2'h3, 2'h0}, {6'h10, 2'h3, 2'h2}};
    lsw_spi_master m (.mclk_in(mclk_in), .so_in(so), .so_oe_in(so_oe),
        .select_n_out(select_n), .sclk_out(sclk), .si_out(si));
    // Short counts keep the watchdog and clock checks quick
    lsw_serial_port #(.WDT_CYC(600), .CLKFAIL_CYC(50), .INT_DIV_CYC(4)) uut (
        .mclk_in(mclk_in), .rst_in(rst_in), .select_n_in(select_n), .sclk_in(sclk),
        .si_in(si), .so_out(so), .so_oe_out(so_oe), .reset_n_in(reset_n_in),
        .wake_in(1'b0), .direct_input_0_in(din[0]), .direct_input_1_in(din[1]),
        .failsafe_config_in(fs_cfg), .vdd_fail_in(vdd_fail), .fault_in(fault),
        .switch_output_0_out(sw0), .switch_output_1_out(sw1), .fault_flag_n_out(flag_n),
        .fault_flag_n_oe_out(flag_oe), .sleep_out(sleep), .failsafe_out(fsafe));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #10 mclk_in = ~mclk_in;
    end
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [10:0] d);
        m.xfer({a, d}, 16, rx);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    // Reset pin pulse, then the settle time the master owes before selecting
    task automatic pulse_reset;
        reset_n_in <= 1'b0;
        wait_cyc(500);
        check("sleep", 16'h1, {15'h0, sleep});
        reset_n_in <= 1'b1;
        wait_cyc(250);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Cycle ceiling; the whole run needs about 6700 cycles
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int r;
        int n;
        wait_cyc(3);
        rst_in <= 1'b0;
        pulse_reset();
        for (r = 0; r < 6; r++) begin
            din <= ROWS[r][3:2];
            wr(`LSW_ADDR_CTRL, {5'h00, ROWS[r][9:4]});
            wait_cyc(5);
            check("switch", {14'h0, ROWS[r][1:0]}, {14'h0, sw1, sw0});
        end
        $display("test table done");
        din <= 2'h1;
        wr(`LSW_ADDR_CTRL, 11'h000);
        wr(`LSW_ADDR_CTRL, 11'h000);
        check("status", 16'h0140, rx);
        din <= 2'h0;
        m.xfer({`LSW_ADDR_CTRL, 11'h003}, 15, rx);
        wait_cyc(5);
        check("short frame", 16'h0, {14'h0, sw1, sw0});
        $display("test status and short frame done");
        wr(`LSW_ADDR_CTRL, 11'h001);
        fault <= 2'h1;
        wait_cyc(1);
        fault <= 2'h0;
        wait_cyc(5);
        check("faulted switch", 16'h0, {15'h0, sw0});
        check("fault flag", 16'h0, {15'h0, flag_level});
        wr(`LSW_ADDR_CTRL, 11'h001);
        check("fault status", 16'h4000, rx);
        wr(`LSW_ADDR_FCLR, 11'h001);
        wait_cyc(5);
        check("flag cleared", 16'h1, {15'h0, flag_level});
        check("switch back", 16'h1, {15'h0, sw0});
        $display("test fault done");
        // Duty 63 on the internal clock: 64 of 128 steps, 4 cycles per step
        wr(`LSW_ADDR_DUTY0, 11'h03f);
        wr(`LSW_ADDR_CTRL, 11'h00d);
        n = 0;
        for (r = 0; r < 512; r++) begin
            @(posedge mclk_in);
            n += sw0;
        end
        check("pwm on count", 16'h0100, n[15:0]);
        $display("test pwm done");
        wr(`LSW_ADDR_CTRL, 11'h00c);
        wait_cyc(100);
        check("internal clock", 16'h1, {15'h0, flag_level});
        wr(`LSW_ADDR_CTRL, 11'h004);
        wait_cyc(100);
        check("clock fail", 16'h0, {15'h0, flag_level});
        $display("test clock fail done");
        fs_cfg <= 1'b1;
        pulse_reset();
        check("flag after reset", 16'h1, {15'h0, flag_level});
        wait_cyc(330);
        check("early failsafe", 16'h0, {15'h0, fsafe});
        wait_cyc(40);
        check("watchdog failsafe", 16'h1, {15'h0, fsafe});
        $display("test watchdog done");
        fs_cfg <= 1'b0;
        pulse_reset();
        check("no failsafe", 16'h0, {15'h0, fsafe});
        vdd_fail <= 1'b1;
        wait_cyc(4);
        check("supply failsafe", 16'h1, {15'h0, fsafe});
        $display("test supply loss done");
        print_verdict();
    end
endmodule
`default_nettype wire
